// [sim/slave_mem_model.sv]
`timescale 1ns/1ps
// Behavioural memory slave with a programmable number of wait cycles per transfer
module slave_mem_model #(
   parameter int DW = 16,
   parameter int BW = 2   // Byte width stays a power of two for dynamic sizing
) (
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic          rd,
   input  wire logic          wr,
   input  wire logic [15:0]   addr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [BW-1:0] be,
   input  wire logic [1:0]    slow,
   output logic      [DW-1:0] rdata,
   output logic               waitreq,
   output logic      [7:0]    xfers
);
   logic [DW-1:0] mem [0:15];
   logic [1:0]    wcnt;

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < 16; i++) begin
         for (int b = 0; b < BW; b++) begin
            mem[i][8*b+:8] = {4'(i), 4'(b)};
         end
      end
   end

   // Holds the request off for slow cycles, then accepts it in one cycle
   assign waitreq = (rd | wr) && (wcnt != slow);
   // Outside the accepting cycle the data is not valid, so show its inverse
   assign rdata   = (rd && !waitreq) ? mem[addr[3:0]] : ~mem[addr[3:0]];

   always @(posedge clk) begin
      if (srst) begin
         wcnt  <= 2'h0;
         xfers <= 8'h00;
      end else if ((rd | wr) && !waitreq) begin
         wcnt  <= 2'h0;
         xfers <= xfers + 8'h01;
         if (wr) begin
            for (int b = 0; b < BW; b++) begin
               if (be[b]) begin
                  mem[addr[3:0]][8*b+:8] <= wdata[8*b+:8];
               end
            end
         end
      end else if (rd | wr) begin
         wcnt <= wcnt + 2'h1;
      end
   end
endmodule

// [sim/tb_data_width_adapter.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
   $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_data_width_adapter;
   logic        clk, srst, narrow_dyn, wide_dyn, m_read, m_write, tgt_wide;
   logic [31:0] m_addr, m_wdata, m_rdata;
   logic [3:0]  m_be;
   logic        m_waitrequest, n_read, n_write, n_waitrequest, w_read, w_write, w_waitrequest;
   logic [15:0] n_addr, n_wdata, n_rdata, w_addr;
   logic [1:0]  n_be, slow_n, slow_w;
   logic [63:0] w_wdata, w_rdata;
   logic [7:0]  w_be, n_xfers, w_xfers;
   int          failures, check_count;

   ////////////////////////////////////////////////////////////////////////////////
   data_width_adapter dut (.clk(clk), .srst(srst), .narrow_dyn(narrow_dyn), .wide_dyn(wide_dyn),
      .m_read(m_read), .m_write(m_write), .tgt_wide(tgt_wide), .m_addr(m_addr), .m_wdata(m_wdata),
      .m_be(m_be), .m_rdata(m_rdata), .m_waitrequest(m_waitrequest), .n_read(n_read), .n_write(n_write),
      .n_addr(n_addr), .n_wdata(n_wdata), .n_be(n_be), .n_rdata(n_rdata), .n_waitrequest(n_waitrequest),
      .w_read(w_read), .w_write(w_write), .w_addr(w_addr), .w_wdata(w_wdata), .w_be(w_be),
      .w_rdata(w_rdata), .w_waitrequest(w_waitrequest));
   slave_mem_model #(.DW(16), .BW(2)) u_nmem (.clk(clk), .srst(srst), .rd(n_read), .wr(n_write),
      .addr(n_addr), .wdata(n_wdata), .be(n_be), .slow(slow_n), .rdata(n_rdata),
      .waitreq(n_waitrequest), .xfers(n_xfers));
   slave_mem_model #(.DW(64), .BW(8)) u_wmem (.clk(clk), .srst(srst), .rd(w_read), .wr(w_write),
      .addr(w_addr), .wdata(w_wdata), .be(w_be), .slow(slow_w), .rdata(w_rdata),
      .waitreq(w_waitrequest), .xfers(w_xfers));

   ////////////////////////////////////////////////////////////////////////////////
   // Initial contents of a model word
   function automatic logic [63:0] pat(input int i, input int nb);
      logic [63:0] v;
      v = '0;
      for (int b = 0; b < nb; b++) v[8*b+:8] = {4'(i), 4'(b)};
      return v;
   endfunction

   // One master transfer, entered at a falling edge; request stays up so calls can run back to back
   task automatic run(input logic wide, input logic dyn, input logic wr, input logic [31:0] addr,
                      input logic [31:0] wd, input logic [3:0] be, input logic [31:0] exp_rd,
                      input int exp_n);
      int         lat;
      int         slow;
      logic [7:0] x0;
      x0       = wide ? w_xfers : n_xfers;
      slow     = wide ? int'(slow_w) : int'(slow_n);
      tgt_wide = wide;
      if (wide) wide_dyn = dyn;
      else narrow_dyn = dyn;
      m_addr  = addr;
      m_wdata = wd;
      m_be    = be;
      m_write = wr;
      m_read  = !wr;
      lat     = 0;
      do begin
         @(posedge clk);
         lat++;
      end while (m_waitrequest !== 1'b0 && lat < 40);
      `CHK(m_rdata, exp_rd)
      `CHK(8'((wide ? w_xfers : n_xfers) - x0), 8'(exp_n))
      `CHK(lat, 2 + exp_n * (slow + 1))
      @(negedge clk);
      `CHK(m_waitrequest, 1'b1)
   endtask

   task automatic idle;
      m_read  = 1'b0;
      m_write = 1'b0;
      @(negedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      `CHK(m_waitrequest, 1'b1)
      `CHK({n_read, n_write, w_read, w_write}, 4'h0)
      `CHK(m_rdata, 32'h0000_0000)
   endtask

   task automatic t_native_narrow;
      run(1'b0, 1'b0, 1'b0, 32'h0000_0008, 32'h0, 4'hf, {16'h0000, 16'(pat(2, 2))}, 1);
      run(1'b0, 1'b0, 1'b1, 32'h0000_000c, 32'hcafe_1234, 4'hf, 32'h0, 1);
      `CHK(u_nmem.mem[3], 16'h1234)
      run(1'b0, 1'b0, 1'b0, 32'h0000_000c, 32'h0, 4'hf, 32'h0000_1234, 1);
      idle();
   endtask

   task automatic t_dyn_narrow;
      slow_n = 2'h2;
      // Slave word 3 still holds what the native write left there
      run(1'b0, 1'b1, 1'b0, 32'h0000_0004, 32'h0, 4'hf, {16'h1234, 16'(pat(2, 2))}, 2);
      run(1'b0, 1'b1, 1'b1, 32'h0000_0008, 32'h5566_7788, 4'hc, 32'h0, 1);
      `CHK(u_nmem.mem[5], 16'h5566)
      `CHK(u_nmem.mem[4], 16'(pat(4, 2)))
      run(1'b0, 1'b1, 1'b0, 32'h0000_0010, 32'h0, 4'h3, {16'h0000, 16'(pat(8, 2))}, 1);
      run(1'b0, 1'b1, 1'b0, 32'h0000_0010, 32'h0, 4'h0, 32'h0, 0);
      slow_n = 2'h0;
      run(1'b0, 1'b1, 1'b0, 32'h0000_0004, 32'h0, 4'hf, {16'h1234, 16'(pat(2, 2))}, 2);
      idle();
   endtask

   task automatic t_wide_dyn;
      logic [63:0] w;
      slow_w = 2'h1;
      // Every byte of the first four wide words, one master word at a time
      for (int i = 0; i < 8; i++) begin
         w = pat(i / 2, 8);
         run(1'b1, 1'b1, 1'b0, 32'h0001_0000 + 32'(4 * i), 32'h0, 4'hf,
             (i % 2) ? w[63:32] : w[31:0], 1);
      end
      slow_w = 2'h0;
      w = pat(1, 8);
      run(1'b1, 1'b1, 1'b1, 32'h0001_000c, 32'haabb_ccdd, 4'h6, 32'h0, 1);
      `CHK(u_wmem.mem[1], {w[63:56], 8'hbb, 8'hcc, w[39:0]})
      run(1'b1, 1'b1, 1'b0, 32'h0001_000c, 32'h0, 4'hf, {w[63:56], 8'hbb, 8'hcc, w[39:32]}, 1);
      idle();
   endtask

   task automatic t_wide_native;
      logic [63:0] w;
      w = pat(4, 8);
      run(1'b1, 1'b0, 1'b0, 32'h0001_0008, 32'h0, 4'hf, 32'(pat(2, 8)), 1);
      run(1'b1, 1'b0, 1'b1, 32'h0001_0010, 32'h0102_0304, 4'hf, 32'h0, 1);
      `CHK(u_wmem.mem[4], {w[63:32], 32'h0102_0304})
      // Other slave keeps its own scheme in the very next transfer
      run(1'b0, 1'b1, 1'b0, 32'h0000_0000, 32'h0, 4'hf, {16'(pat(1, 2)), 16'(pat(0, 2))}, 2);
      idle();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Whole run is about a hundred cycles; the 5000-cycle limit leaves wide margin
   initial begin
      #500000;
      failures++;
      test_done();
   end

   initial begin
      srst       = 1'b1;
      narrow_dyn = 1'b0; // Each slave's scheme is chosen on its own input
      wide_dyn   = 1'b1; // Dynamic sizing preferred for new slaves
      {m_read, m_write, tgt_wide} = 3'h0;
      m_addr     = 32'h0;
      m_wdata    = 32'h0;
      m_be       = 4'h0;
      slow_n     = 2'h0;
      slow_w     = 2'h0;
      failures   = 0;
      check_count = 0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      t_reset();
      srst = 1'b0;
      @(negedge clk);
      t_reset();
      t_native_narrow();
      t_dyn_narrow();
      t_wide_dyn();
      t_wide_native();
      test_done();
   end
endmodule

// [src/data_width_adapter.sv]
`timescale 1ns/1ps
module data_width_adapter (
   input  wire logic                     clk,
   input  wire logic                     srst,
   // Slave alignment selections
   input  wire logic                     narrow_dyn,
   input  wire logic                     wide_dyn,
   // Master port
   input  wire logic                     m_read,
   input  wire logic                     m_write,
   input  wire logic                     tgt_wide,
   input  wire logic [31:0]              m_addr,
   input  wire logic [dwa_pkg::M_DW-1:0] m_wdata,
   input  wire logic [dwa_pkg::M_BW-1:0] m_be,
   output logic      [dwa_pkg::M_DW-1:0] m_rdata,
   output logic                          m_waitrequest,
   // 16-bit slave port
   output logic                          n_read,
   output logic                          n_write,
   output logic      [dwa_pkg::S_AW-1:0] n_addr,
   output logic      [dwa_pkg::N_DW-1:0] n_wdata,
   output logic      [dwa_pkg::N_BW-1:0] n_be,
   input  wire logic [dwa_pkg::N_DW-1:0] n_rdata,
   input  wire logic                     n_waitrequest,
   // 64-bit slave port
   output logic                          w_read,
   output logic                          w_write,
   output logic      [dwa_pkg::S_AW-1:0] w_addr,
   output logic      [dwa_pkg::W_DW-1:0] w_wdata,
   output logic      [dwa_pkg::W_BW-1:0] w_be,
   input  wire logic [dwa_pkg::W_DW-1:0] w_rdata,
   input  wire logic                     w_waitrequest
);

   typedef struct packed {
      dwa_pkg::state_type           st;
      logic                         wr;
      logic                         dyn;
      logic                         hi;
      logic                         sl;
      logic                         more;
      logic [dwa_pkg::M_DW-1:0]     wdat;
      logic [dwa_pkg::M_BW-1:0]     mbe;
      logic [dwa_pkg::M_DW-1:0]     acc;
      logic                         m_wait;
      logic [dwa_pkg::M_DW-1:0]     m_rdata;
      logic                         n_rd;
      logic                         n_wr;
      logic [dwa_pkg::S_AW-1:0]     n_addr;
      logic [dwa_pkg::N_DW-1:0]     n_wdata;
      logic [dwa_pkg::N_BW-1:0]     n_be;
      logic                         w_rd;
      logic                         w_wr;
      logic [dwa_pkg::S_AW-1:0]     w_addr;
      logic [dwa_pkg::W_DW-1:0]     w_wdata;
      logic [dwa_pkg::W_BW-1:0]     w_be;
   } regs_type;

   regs_type                     q;
   regs_type                     d;
   logic     [31:0]              off_n;
   logic     [31:0]              off_w;
   logic     [dwa_pkg::M_BW-1:0] plan_be_in;
   logic     [dwa_pkg::M_DW-1:0] plan_wd_in;
   logic                         plan_idx;
   logic     [1:0]               plan_need;
   logic     [dwa_pkg::N_BW-1:0] plan_be;
   logic     [dwa_pkg::N_DW-1:0] plan_wd;
   logic                         steer_dyn;
   logic                         steer_half;
   logic     [dwa_pkg::W_DW-1:0] steer_wd;
   logic     [dwa_pkg::W_BW-1:0] steer_be;
   logic     [dwa_pkg::M_DW-1:0] steer_rd;

   ////////////////////////////////////////////////////////////////////////////
   // Offsets inside each slave's window
   assign off_n = m_addr - dwa_pkg::N_BASE;
   assign off_w = m_addr - dwa_pkg::W_BASE;

   // Planner sees the live request while idle, the held word afterwards
   assign plan_be_in = (q.st == dwa_pkg::ST_IDLE) ? m_be : q.mbe;
   assign plan_wd_in = (q.st == dwa_pkg::ST_IDLE) ? m_wdata : q.wdat;
   assign plan_idx   = (q.st == dwa_pkg::ST_IDLE) ? ~plan_need[0] : 1'b1;

   slice_planner u_plan (
      .be          (plan_be_in),
      .wdata       (plan_wd_in),
      .idx         (plan_idx),
      .need        (plan_need),
      .slice_be    (plan_be),
      .slice_wdata (plan_wd)
   );

   assign steer_dyn  = (q.st == dwa_pkg::ST_IDLE) ? wide_dyn : q.dyn;
   assign steer_half = (q.st == dwa_pkg::ST_IDLE) ? off_w[dwa_pkg::W_HALF_BIT] : q.hi;

   lane_steer u_steer (
      .dyn     (steer_dyn),
      .half    (steer_half),
      .m_wdata (m_wdata),
      .m_be    (m_be),
      .s_rdata (w_rdata),
      .s_wdata (steer_wd),
      .s_be    (steer_be),
      .m_rdata (steer_rd)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      d = q;
      unique case (q.st)
         dwa_pkg::ST_IDLE: begin
            d.m_wait = 1'b1;
            if (m_read || m_write) begin
               d.wr   = m_write;
               d.wdat = m_wdata;
               d.mbe  = m_be;
               d.acc  = '0;
               if (tgt_wide) begin
                  // Each alignment choice belongs to the slave being served
                  d.dyn = wide_dyn;
                  d.hi  = off_w[dwa_pkg::W_HALF_BIT];
                  if (wide_dyn) begin
                     d.w_addr = off_w[dwa_pkg::W_WORD_LSB +: dwa_pkg::S_AW];
                  end else begin
                     d.w_addr = off_w[dwa_pkg::M_WORD_LSB +: dwa_pkg::S_AW];
                  end
                  d.w_wdata = steer_wd;
                  d.w_be    = steer_be;
                  d.w_rd    = m_read & ~m_write;
                  d.w_wr    = m_write;
                  d.st      = dwa_pkg::ST_WIDE;
               end else if (!narrow_dyn) begin
                  d.dyn     = 1'b0;
                  d.sl      = 1'b0;
                  d.more    = 1'b0;
                  d.n_addr  = off_n[dwa_pkg::M_WORD_LSB +: dwa_pkg::S_AW];
                  d.n_wdata = m_wdata[15:0];
                  d.n_be    = m_be[1:0];
                  d.n_rd    = m_read & ~m_write;
                  d.n_wr    = m_write;
                  d.st      = dwa_pkg::ST_NARROW;
               end else if (plan_need == 2'b00) begin
                  // No lane enabled: nothing for the slave, finish at once
                  d.dyn     = 1'b1;
                  d.m_rdata = '0;
                  d.m_wait  = 1'b0;
                  d.st      = dwa_pkg::ST_RESP;
               end else begin
                  d.dyn     = 1'b1;
                  d.sl      = plan_idx;
                  d.more    = plan_need[0] & plan_need[1];
                  d.n_addr  = {off_n[dwa_pkg::M_WORD_LSB +: dwa_pkg::S_AW-1], plan_idx};
                  d.n_wdata = plan_wd;
                  d.n_be    = plan_be;
                  d.n_rd    = m_read & ~m_write;
                  d.n_wr    = m_write;
                  d.st      = dwa_pkg::ST_NARROW;
               end
            end
         end
         dwa_pkg::ST_NARROW: begin
            if (!n_waitrequest) begin
               if (!q.wr) begin
                  if (q.sl) begin
                     d.acc[31:16] = n_rdata;
                  end else begin
                     d.acc[15:0] = n_rdata;
                  end
               end
               if (q.more) begin
                  // Master keeps waiting while the second slice runs
                  d.sl      = 1'b1;
                  d.more    = 1'b0;
                  d.n_addr  = {q.n_addr[15:1], 1'b1};
                  d.n_wdata = plan_wd;
                  d.n_be    = plan_be;
               end else begin
                  d.n_rd    = 1'b0;
                  d.n_wr    = 1'b0;
                  d.m_rdata = d.acc;
                  d.m_wait  = 1'b0;
                  d.st      = dwa_pkg::ST_RESP;
               end
            end
         end
         dwa_pkg::ST_WIDE: begin
            if (!w_waitrequest) begin
               d.w_rd    = 1'b0;
               d.w_wr    = 1'b0;
               d.m_rdata = q.wr ? '0 : steer_rd;
               d.m_wait  = 1'b0;
               d.st      = dwa_pkg::ST_RESP;
            end
         end
         dwa_pkg::ST_RESP: begin
            // One cycle with the wait lowered completes the master transfer
            d.m_wait = 1'b1;
            d.st     = dwa_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q        <= '0;
         q.m_wait <= dwa_pkg::WAIT_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign m_rdata       = q.m_rdata;
   assign m_waitrequest = q.m_wait;
   assign n_read        = q.n_rd;
   assign n_write       = q.n_wr;
   assign n_addr        = q.n_addr;
   assign n_wdata       = q.n_wdata;
   assign n_be          = q.n_be;
   assign w_read        = q.w_rd;
   assign w_write       = q.w_wr;
   assign w_addr        = q.w_addr;
   assign w_wdata       = q.w_wdata;
   assign w_be          = q.w_be;

   ////////////////////////////////////////////////////////////////////////////
   property p_wait_during_slave;
      @(posedge clk) disable iff (srst)
      (q.n_rd || q.n_wr || q.w_rd || q.w_wr) |-> q.m_wait;
   endproperty
   a_wait_during_slave:
      assert property (p_wait_during_slave) else $error("master released while slave busy");

   property p_wait_one_cycle;
      @(posedge clk) disable iff (srst)
      !q.m_wait |=> q.m_wait && q.st == dwa_pkg::ST_IDLE;
   endproperty
   a_wait_one_cycle:
      assert property (p_wait_one_cycle) else $error("wait low longer than one cycle");

   property p_no_empty_slice;
      @(posedge clk) disable iff (srst)
      (q.n_wr && q.dyn) |-> q.n_be != 2'b00;
   endproperty
   a_no_empty_slice:
      assert property (p_no_empty_slice) else $error("slice with no enabled byte issued");

   property p_native_upper_zero;
      @(posedge clk) disable iff (srst)
      (q.st == dwa_pkg::ST_NARROW && !q.dyn && !q.wr && !n_waitrequest) |=> m_rdata[31:16] == 16'h0000;
   endproperty
   a_native_upper_zero:
      assert property (p_native_upper_zero) else $error("native read upper half not zero");

   property p_native_wide_low;
      @(posedge clk) disable iff (srst)
      (q.w_wr && !q.dyn) |-> (w_be[7:4] == 4'h0 && w_wdata[63:32] == 32'h0000_0000);
   endproperty
   a_native_wide_low:
      assert property (p_native_wide_low) else $error("native write reached upper slave half");

   property p_wide_single;
      @(posedge clk) disable iff (srst)
      ((q.w_rd || q.w_wr) && !w_waitrequest) |=> !(w_read || w_write) && !m_waitrequest;
   endproperty
   a_wide_single:
      assert property (p_wide_single) else $error("wide slave saw more than one transfer");

   property p_dyn_one_half;
      @(posedge clk) disable iff (srst)
      (q.w_wr && q.dyn) |-> (w_be[7:4] == 4'h0 || w_be[3:0] == 4'h0);
   endproperty
   a_dyn_one_half:
      assert property (p_dyn_one_half) else $error("write enabled both slave halves");

   property p_odd_high_half;
      @(posedge clk) disable iff (srst)
      (q.w_rd && q.dyn && q.hi && !w_waitrequest) |=> m_rdata == $past(w_rdata[63:32]);
   endproperty
   a_odd_high_half:
      assert property (p_odd_high_half) else $error("odd word not taken from upper half");

   property p_upper_slice;
      @(posedge clk) disable iff (srst)
      (q.n_rd && q.dyn && q.sl && !n_waitrequest) |=> (m_rdata[31:16] == $past(n_rdata)) && !m_waitrequest;
   endproperty
   a_upper_slice:
      assert property (p_upper_slice) else $error("slice 2N+1 not in upper half");

endmodule

// [src/dwa_pkg.sv]
package dwa_pkg;

   // Port widths
   localparam int M_DW = 32;
   localparam int M_BW = 4;
   localparam int N_DW = 16;
   localparam int N_BW = 2;
   localparam int W_DW = 64;
   localparam int W_BW = 8;
   localparam int S_AW = 16;

   // Number of narrow slices in one master word
   localparam int N_SLICES = 2;

   // Slave bases in the master's byte address space
   localparam logic [31:0] N_BASE = 32'h0000_0000;
   localparam logic [31:0] W_BASE = 32'h0001_0000;

   // Offset bit positions: master word index starts at bit 2, wide word at bit 3
   localparam int M_WORD_LSB = 2;
   localparam int W_WORD_LSB = 3;
   localparam int W_HALF_BIT = 2;

   // Values after reset
   localparam logic WAIT_RST = 1'b1;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_NARROW,
      ST_WIDE,
      ST_RESP
   } state_type;

endpackage

// [src/lane_steer.sv]
`timescale 1ns/1ps
// Lane placement toward the 64-bit slave and steering back to the master
module lane_steer (
   input  wire logic                     dyn,
   input  wire logic                     half,
   input  wire logic [dwa_pkg::M_DW-1:0] m_wdata,
   input  wire logic [dwa_pkg::M_BW-1:0] m_be,
   input  wire logic [dwa_pkg::W_DW-1:0] s_rdata,
   output logic      [dwa_pkg::W_DW-1:0] s_wdata,
   output logic      [dwa_pkg::W_BW-1:0] s_be,
   output logic      [dwa_pkg::M_DW-1:0] m_rdata
);

   always_comb begin
      if (!dyn) begin
         // Plain wires: upper slave half is never reached
         s_wdata = {32'h0000_0000, m_wdata};
         s_be    = {4'h0, m_be};
         m_rdata = s_rdata[31:0];
      end else begin
         // Data replicated on both halves; byte enables pick the addressed one
         s_wdata = {m_wdata, m_wdata};
         s_be    = half ? {m_be, 4'h0} : {4'h0, m_be};
         m_rdata = half ? s_rdata[63:32] : s_rdata[31:0];
      end
   end

endmodule

// [src/slice_planner.sv]
`timescale 1ns/1ps
// Picks the narrow slices a wide master word needs and the lanes of one slice
module slice_planner (
   input  wire logic [dwa_pkg::M_BW-1:0]     be,
   input  wire logic [dwa_pkg::M_DW-1:0]     wdata,
   input  wire logic                         idx,
   output logic      [dwa_pkg::N_SLICES-1:0] need,
   output logic      [dwa_pkg::N_BW-1:0]     slice_be,
   output logic      [dwa_pkg::N_DW-1:0]     slice_wdata
);

   ////////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < dwa_pkg::N_SLICES; g++) begin : g_slice
         assign need[g] = |be[g*dwa_pkg::N_BW +: dwa_pkg::N_BW];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   assign slice_be    = idx ? be[3:2] : be[1:0];
   assign slice_wdata = idx ? wdata[31:16] : wdata[15:0];

endmodule
